// >>> bench/sclr_synth_model.sv
`timescale 1ns/1ps

// synthesizer comparators and diagnostic pins as the register block sees them
module sclr_synth_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // requested state from the bench
    input wire logic [1:0] want_code,
    input wire logic [5:0] want_diag,
    input wire logic slow,
    // pins
    output logic lock_above_flag,
    output logic lock_below_flag,
    output logic [2:0] factory_amp_diag_hi,
    output logic [2:0] factory_amp_diag_sel
);
    logic [2:0] cnt_q;
    logic [2:0] lag;

    // a slow loop settles four cycles late, a prompt one at once
    assign lag = slow ? 3'h4 : 3'h0;

    // comparator pair, 10 only on command
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {lock_above_flag, lock_below_flag} <= 2'h0;
            cnt_q <= 3'h0;
        end
        else if ({lock_above_flag, lock_below_flag} != want_code)
        begin
            cnt_q <= (cnt_q == lag) ? 3'h0 : cnt_q + 3'h1;
            if (cnt_q == lag)
                {lock_above_flag, lock_below_flag} <= want_code;
        end
        else
            cnt_q <= 3'h0;
    end

    assign factory_amp_diag_hi = want_diag[5:3];
    assign factory_amp_diag_sel = want_diag[2:0];
endmodule : sclr_synth_model

// >>> bench/tb.sv
`timescale 1ns/1ps

module tb;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, slow;
    logic lock_above_flag, lock_below_flag;
    logic [7:0] paddr, row_ten, row_eleven, synth_loop_slew_control, e10, e11, v;
    logic [31:0] pwdata, prdata, d;
    logic [2:0] factory_amp_diag_hi, factory_amp_diag_sel;
    logic [1:0] want_code;
    logic [5:0] want_diag;
    logic [1:0] codes [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    logic pe;
    int errors, checks, seed;

    sclr_regs i_sclr_regs (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lock_above_flag(lock_above_flag), .lock_below_flag(lock_below_flag),
        .factory_amp_diag_hi(factory_amp_diag_hi), .factory_amp_diag_sel(factory_amp_diag_sel),
        .row_ten(row_ten), .row_eleven(row_eleven),
        .synth_loop_slew_control(synth_loop_slew_control), .irq(irq));

    sclr_synth_model i_sclr_synth_model (.pclk(pclk), .presetn(presetn),
        .want_code(want_code), .want_diag(want_diag), .slow(slow),
        .lock_above_flag(lock_above_flag), .lock_below_flag(lock_below_flag),
        .factory_amp_diag_hi(factory_amp_diag_hi), .factory_amp_diag_sel(factory_amp_diag_sel));

    // ----------------------------------------
    // expectations
    // ----------------------------------------
    // {band, divider} of one channel, indices in ascending frequency
    function automatic logic [7:0] exp_chan(input logic r5, input logic [3:0] i);
        logic [4:0] dv;
        logic [2:0] bd;
        dv = r5 ? 5'(i) + 5'h01 : (i < 4'h6) ? 5'h15 - 5'(i) : (i == 4'h6) ? 5'h1F : 5'(i) - 5'h07;
        bd = r5 ? 3'(i >> 1) : 3'(i >> 1) + 3'h1;
        return {bd, dv};
    endfunction : exp_chan

    // lock byte: code, diag high bits, select bits in reversed order
    function automatic logic [7:0] exp_lock(input logic [1:0] c, input logic [5:0] g);
        return {c, g[5:3], g[0], g[1], g[2]};
    endfunction : exp_lock

    // ----------------------------------------
    // bus and checks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; only the watchdog ends a hung wait
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("prdata", exp, r);
        chk("pslverr", 32'(ee), 32'(e));
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, wd, r, e);
        chk("pslverr", 32'(ee), 32'(e));
    endtask : wr

    // move the comparators, then let synchronisers and status settle
    task automatic lock_to(input logic [1:0] c);
        want_code <= c;
        want_diag <= 6'($random(seed));
        slow <= 1'($random(seed));
        repeat (14) @(posedge pclk);
    endtask : lock_to

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // watchdog, about fifty times the expected run
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        give_verdict();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, want_code, want_diag, slow} = '0;
        {errors, checks} = '0;
        ce = 1'b1;
        seed = 48;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(sclr_pkg::OFF_ROW_TEN, 32'hF0, 1'b0);
        rd(sclr_pkg::OFF_ROW_ELEVEN, 32'h01, 1'b0);
        rd(sclr_pkg::OFF_LOOP_SLEW, 32'h76, 1'b0);
        rd(sclr_pkg::OFF_IRQ_MASK, 32'h0, 1'b0);
        rd(sclr_pkg::OFF_CHAN_APPLY, 32'h0, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            d = $random(seed);
            wr(sclr_pkg::OFF_ROW_TEN, d, 1'b0);
            rd(sclr_pkg::OFF_ROW_TEN, {24'h0, d[7:0]}, 1'b0);
            wr(sclr_pkg::OFF_LOOP_SLEW, d, 1'b0);
            chk("loop_slew", 32'(d[7:0]), 32'(synth_loop_slew_control));
        end
        wr(8'h20, 32'hFFFF, 1'b1);
        rd(8'h20, 32'h0, 1'b1);
        // readback select low hides the lock byte
        wr(sclr_pkg::OFF_LOOP_SLEW, 32'h36, 1'b0);
        lock_to(2'h1);
        rd(sclr_pkg::OFF_LOCK_DIAG, 32'h0, 1'b0);
        wr(sclr_pkg::OFF_LOOP_SLEW, 32'h76, 1'b0);
        // every comparator code: loss, fault, none, gain
        foreach (codes[k])
        begin
            lock_to(codes[k]);
            rd(sclr_pkg::OFF_LOCK_DIAG, 32'(exp_lock(codes[k], want_diag)), 1'b0);
        end
        wr(sclr_pkg::OFF_LOCK_DIAG, 32'h3F, 1'b0);
        rd(sclr_pkg::OFF_LOCK_DIAG, 32'(exp_lock(2'h1, want_diag)), 1'b0);
        // interrupt: raise, mask, clear
        rd(sclr_pkg::OFF_IRQ_STATUS, 32'h7, 1'b0);
        chk("irq", 32'h0, 32'(irq));
        wr(sclr_pkg::OFF_IRQ_MASK, 32'h4, 1'b0);
        // irq follows the mask one edge after it lands
        @(posedge pclk);
        chk("irq", 32'h1, 32'(irq));
        wr(sclr_pkg::OFF_IRQ_STATUS, 32'h4, 1'b0);
        rd(sclr_pkg::OFF_IRQ_STATUS, 32'h3, 1'b0);
        chk("irq", 32'h0, 32'(irq));
        lock_to(2'h2);
        chk("irq", 32'h1, 32'(irq));
        wr(sclr_pkg::OFF_IRQ_STATUS, 32'h7, 1'b0);
        chk("irq", 32'h0, 32'(irq));
        // channel table for both references, rows around the fields kept
        e10 = 8'($random(seed));
        e11 = 8'($random(seed));
        wr(sclr_pkg::OFF_ROW_TEN, 32'(e10), 1'b0);
        wr(sclr_pkg::OFF_ROW_ELEVEN, 32'(e11), 1'b0);
        for (int rf = 0; rf < 2; rf++)
        begin
            for (int i = 0; i < (rf ? 15 : 13); i++)
            begin
                v = exp_chan(1'(rf), 4'(i));
                wr(sclr_pkg::OFF_CHAN_APPLY, 32'(rf * 16 + i), 1'b0);
                e10 = {e10[7:1], v[4]};
                e11 = {v[3:0], v[7:5], e11[0]};
                chk("row_ten", 32'(e10), 32'(row_ten));
                chk("row_eleven", 32'(e11), 32'(row_eleven));
                rd(sclr_pkg::OFF_SYNTH_VIEW, 32'(v), 1'b0);
            end
        end
        wr(sclr_pkg::OFF_CHAN_APPLY, 32'h0D, 1'b1);
        wr(sclr_pkg::OFF_CHAN_APPLY, 32'h1F, 1'b1);
        chk("row_eleven", 32'(e11), 32'(row_eleven));
        // poll the lock indicator after a retune until it reads locked
        want_code <= 2'h1;
        slow <= 1'b1;
        do apb(1'b0, sclr_pkg::OFF_LOCK_DIAG, 32'h0, d, pe); while (d[7:6] !== 2'h1);
        chk("lock_poll", 32'(exp_lock(2'h1, want_diag)), d);
        rd(sclr_pkg::OFF_CHAN_APPLY, 32'h1E, 1'b0);
        give_verdict();
    end
endmodule : tb

// >>> verilog/sclr_chan_lut.sv
`timescale 1ns/1ps

// channel index to divider and band codes for both reference clocks
module sclr_chan_lut (
    // request
    input wire logic ref_500,
    input wire logic [3:0] chan_idx,
    // result
    output logic [4:0] div_code,
    output logic [2:0] band_code,
    output logic chan_ok
);

    logic [4:0] idx5;
    logic [4:0] div_540;
    logic [4:0] div_500;
    logic [2:0] band_540;
    logic [2:0] band_500;

    assign idx5 = {1'b0, chan_idx};

    // 540 MHz plan: counts down from the top, one wrap code, then up from zero
    assign div_540 = (chan_idx < sclr_pkg::CHAN_WRAP_540) ? 5'(sclr_pkg::DIV_TOP_540 - idx5)
        : (chan_idx == sclr_pkg::CHAN_WRAP_540) ? sclr_pkg::DIV_WRAP_540
        : 5'(idx5 - 5'h07);
    assign band_540 = 3'(chan_idx[3:1] + 3'h1);

    // 500 MHz plan: divider one above index, band steps every two channels
    assign div_500 = 5'(idx5 + 5'h01);
    assign band_500 = chan_idx[3:1];

    assign div_code = ref_500 ? div_500 : div_540;
    assign band_code = ref_500 ? band_500 : band_540;
    assign chan_ok = ref_500 ? (chan_idx < sclr_pkg::CHAN_CNT_500)
        : (chan_idx < sclr_pkg::CHAN_CNT_540);

endmodule : sclr_chan_lut

// >>> verilog/sclr_pin_sync.sv
`timescale 1ns/1ps

// three-stage input filter; output moves only when stages two and three agree
module sclr_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_d;

    // per-bit agreement so one noisy bit does not hold back the others
    assign agree = ~(s2_q ^ s3_q);
    assign level_d = (s3_q & agree) | (level_out & ~agree);

    // s1 feeds s2 only, never logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_out <= '0;
        end
        else if (ce)
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_out <= level_d;
        end
    end

endmodule : sclr_pin_sync

// >>> verilog/sclr_pkg.sv
package sclr_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_ROW_TEN = 8'h00;
    localparam logic [7:0] OFF_ROW_ELEVEN = 8'h04;
    localparam logic [7:0] OFF_LOOP_SLEW = 8'h08;
    localparam logic [7:0] OFF_LOCK_DIAG = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_CHAN_APPLY = 8'h18;
    localparam logic [7:0] OFF_SYNTH_VIEW = 8'h1C;

    // ----------------------------------------
    // reset values (normal operation settings)
    // ----------------------------------------
    localparam logic [7:0] RST_ROW_TEN = 8'hF0;
    localparam logic [7:0] RST_ROW_ELEVEN = 8'h01;
    localparam logic [7:0] RST_LOOP_SLEW = 8'h76;
    localparam logic [4:0] RST_CHAN_APPLY = 5'h00;
    localparam logic [2:0] RST_IRQ = 3'h0;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int DIV_MSB_POS = 0;
    localparam int DIV_LSB_HI = 7;
    localparam int DIV_LSB_LO = 4;
    localparam int BAND_HI = 3;
    localparam int BAND_LO = 1;
    localparam int READBACK_SEL_POS = 6;
    localparam int LEVEL_LOOP_HI = 3;
    localparam int LEVEL_LOOP_LO = 2;
    localparam int SLEW_HI = 1;
    localparam int SLEW_LO = 0;
    localparam int CHAN_REF_POS = 4;
    localparam int IRQ_GAIN_POS = 0;
    localparam int IRQ_LOSS_POS = 1;
    localparam int IRQ_FAULT_POS = 2;

    // ----------------------------------------
    // lock indicator codes {above, below}
    // ----------------------------------------
    localparam logic [1:0] LOCK_BELOW = 2'h0;
    localparam logic [1:0] LOCK_IN = 2'h1;
    localparam logic [1:0] LOCK_FAULT = 2'h2;
    localparam logic [1:0] LOCK_ABOVE = 2'h3;

    // ----------------------------------------
    // channel table sizes
    // ----------------------------------------
    localparam logic [3:0] CHAN_CNT_540 = 4'hD;
    localparam logic [3:0] CHAN_CNT_500 = 4'hF;
    localparam logic [3:0] CHAN_WRAP_540 = 4'h6;
    localparam logic [4:0] DIV_TOP_540 = 5'h15;
    localparam logic [4:0] DIV_WRAP_540 = 5'h1F;

endpackage : sclr_pkg

// >>> verilog/sclr_regs.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - The two-bit lock indicator sits in bits 7:6 of the lock register and ignores writes.
// - The lock indicator reads 01 while the control voltage is inside the lock window.
// - The lock indicator reads 11 above the window and 00 below it.
// - Code 10 is illegal, is reported as a fault, and must never be taken as lock.
// - Bits 5:0 of the lock register are read-only factory diagnostics.
// - The divider code is row ten bit 0 as MSB over row eleven bits 7:4.
// - The lock register reads back only while the readback-select bit is high.
module sclr_regs (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // synthesizer pins (asynchronous)
    input wire logic lock_above_flag,
    input wire logic lock_below_flag,
    input wire logic [2:0] factory_amp_diag_hi,
    input wire logic [2:0] factory_amp_diag_sel,
    // control rows to the synthesizer
    output logic [7:0] row_ten,
    output logic [7:0] row_eleven,
    output logic [7:0] synth_loop_slew_control,
    // interrupt
    output logic irq
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] row_ten_q;
    logic [7:0] row_eleven_q;
    logic [7:0] loop_slew_q;
    logic [4:0] chan_q;
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] mask_q;
    logic [1:0] lock_prev_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;

    // ----------------------------------------
    // pin inputs
    // ----------------------------------------
    logic [1:0] lock_raw;
    logic [1:0] lock_code;
    logic [5:0] diag_raw;
    logic [5:0] diag_sync;

    // bit 7 above, bit 6 below; bits 2:0 carry the select field reversed
    assign lock_raw = {lock_above_flag, lock_below_flag};
    assign diag_raw = {factory_amp_diag_hi, factory_amp_diag_sel[0], factory_amp_diag_sel[1],
        factory_amp_diag_sel[2]};

    sclr_pin_sync #(.WIDTH(2)) u_lock_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin_in(lock_raw),
        .level_out(lock_code)
    );

    sclr_pin_sync #(.WIDTH(6)) u_diag_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin_in(diag_raw),
        .level_out(diag_sync)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic setup;
    logic access;
    logic wr;
    logic hit_ten;
    logic hit_eleven;
    logic hit_slew;
    logic hit_lock;
    logic hit_stat;
    logic hit_mask;
    logic hit_chan;
    logic hit_view;
    logic addr_ok;

    // setup arms pready, so every transfer ends on its first access cycle
    assign setup = psel & ~penable;
    assign access = psel & penable & pready_q;
    assign wr = access & pwrite;
    assign hit_ten = (paddr == sclr_pkg::OFF_ROW_TEN);
    assign hit_eleven = (paddr == sclr_pkg::OFF_ROW_ELEVEN);
    assign hit_slew = (paddr == sclr_pkg::OFF_LOOP_SLEW);
    assign hit_lock = (paddr == sclr_pkg::OFF_LOCK_DIAG);
    assign hit_stat = (paddr == sclr_pkg::OFF_IRQ_STATUS);
    assign hit_mask = (paddr == sclr_pkg::OFF_IRQ_MASK);
    assign hit_chan = (paddr == sclr_pkg::OFF_CHAN_APPLY);
    assign hit_view = (paddr == sclr_pkg::OFF_SYNTH_VIEW);
    assign addr_ok = hit_ten | hit_eleven | hit_slew | hit_lock | hit_stat | hit_mask
        | hit_chan | hit_view;

    // ----------------------------------------
    // channel lookup
    // ----------------------------------------
    logic [4:0] lut_div;
    logic [2:0] lut_band;
    logic lut_ok;
    logic chan_wr;
    logic chan_bad;

    // 540 MHz plan / 500 MHz plan
    sclr_chan_lut u_lut (
        .ref_500(pwdata[sclr_pkg::CHAN_REF_POS]),
        .chan_idx(pwdata[3:0]),
        .div_code(lut_div),
        .band_code(lut_band),
        .chan_ok(lut_ok)
    );

    // an index past the plan is refused with an error and changes nothing
    assign chan_wr = wr & hit_chan & lut_ok;
    assign chan_bad = pwrite & hit_chan & ~lut_ok;

    // ----------------------------------------
    // control rows
    // ----------------------------------------
    logic [7:0] row_ten_d;
    logic [7:0] row_eleven_d;
    logic [4:0] div_now;
    logic [2:0] band_now;

    assign row_ten_d = chan_wr ? {row_ten_q[7:1], lut_div[4]}
        : (wr & hit_ten) ? pwdata[7:0] : row_ten_q;
    assign row_eleven_d = chan_wr ? {lut_div[3:0], lut_band, row_eleven_q[0]}
        : (wr & hit_eleven) ? pwdata[7:0] : row_eleven_q;
    assign div_now = {row_ten_q[sclr_pkg::DIV_MSB_POS],
        row_eleven_q[sclr_pkg::DIV_LSB_HI:sclr_pkg::DIV_LSB_LO]};
    assign band_now = row_eleven_q[sclr_pkg::BAND_HI:sclr_pkg::BAND_LO];

    // level loop and slew are plain software fields, reset to normal values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            row_ten_q <= sclr_pkg::RST_ROW_TEN;
            row_eleven_q <= sclr_pkg::RST_ROW_ELEVEN;
            loop_slew_q <= sclr_pkg::RST_LOOP_SLEW;
            chan_q <= sclr_pkg::RST_CHAN_APPLY;
            mask_q <= sclr_pkg::RST_IRQ;
        end
        else if (ce)
        begin
            row_ten_q <= row_ten_d;
            row_eleven_q <= row_eleven_d;
            if (wr && hit_slew)
                loop_slew_q <= pwdata[7:0];
            if (chan_wr)
                chan_q <= pwdata[4:0];
            if (wr && hit_mask)
                mask_q <= pwdata[2:0];
        end
    end

    // ----------------------------------------
    // lock events and interrupt
    // ----------------------------------------
    logic ev_gain;
    logic ev_loss;
    logic ev_fault;
    logic [2:0] ev;
    logic [2:0] w1c;

    // entering lock, leaving it, illegal code is a fault
    assign ev_gain = (lock_code == sclr_pkg::LOCK_IN) & (lock_prev_q != sclr_pkg::LOCK_IN);
    assign ev_loss = (lock_code != sclr_pkg::LOCK_IN) & (lock_prev_q == sclr_pkg::LOCK_IN);
    assign ev_fault = (lock_code == sclr_pkg::LOCK_FAULT)
        & (lock_prev_q != sclr_pkg::LOCK_FAULT);
    assign ev = {ev_fault, ev_loss, ev_gain};
    assign w1c = (wr & hit_stat) ? pwdata[2:0] : 3'h0;
    // a new event outranks a clear in the same cycle
    assign stat_d = (stat_q & ~w1c) | ev;

    // prev code starts at below-window so a first in-lock reading counts as a gain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_prev_q <= sclr_pkg::LOCK_BELOW;
            stat_q <= sclr_pkg::RST_IRQ;
            irq_q <= 1'b0;
        end
        else if (ce)
        begin
            lock_prev_q <= lock_code;
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic readback_sel;
    logic [7:0] lock_word;
    logic [31:0] rmux;

    // readback gate, lock code on top, diagnostics below
    assign readback_sel = loop_slew_q[sclr_pkg::READBACK_SEL_POS];
    assign lock_word = readback_sel ? {lock_code, diag_sync} : 8'h00;

    assign rmux = hit_ten ? {24'h0, row_ten_q}
        : hit_eleven ? {24'h0, row_eleven_q}
        : hit_slew ? {24'h0, loop_slew_q}
        : hit_lock ? {24'h0, lock_word}
        : hit_stat ? {29'h0, stat_q}
        : hit_mask ? {29'h0, mask_q}
        : hit_chan ? {27'h0, chan_q}
        : hit_view ? {24'h0, band_now, div_now}
        : 32'h0;

    // data captured at setup; lock bits are at most one cycle old at completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else if (ce)
        begin
            pready_q <= setup;
            pslverr_q <= setup & (~addr_ok | chan_bad);
            if (setup)
                prdata_q <= pwrite ? 32'h0 : rmux;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign row_ten = row_ten_q;
    assign row_eleven = row_eleven_q;
    assign synth_loop_slew_control = loop_slew_q;
    assign irq = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (ce && setup |=> pready_q)
        else $error("pready not raised after setup");

    a_lock_ro_write: assert property (ce && wr && hit_lock |=> $stable(row_ten_q)
        && $stable(row_eleven_q) && $stable(loop_slew_q) && $stable(mask_q))
        else $error("write to lock register altered a control row");

    a_lock_gain_flag: assert property (ce && lock_code == 2'h1 && lock_prev_q != 2'h1
        |=> stat_q[0])
        else $error("entering lock did not set gain status");

    a_lock_loss_flag: assert property (ce && lock_prev_q == 2'h1 && lock_code == 2'h3
        |=> stat_q[1])
        else $error("leaving lock above window did not set loss status");

    a_fault_irq: assert property (ce && mask_q[2] && lock_code == 2'h2 && lock_prev_q != 2'h2
        |=> stat_q[2] && irq_q)
        else $error("illegal lock code did not raise fault interrupt");

    a_diag_readback: assert property (ce && setup && !pwrite && hit_lock && readback_sel
        |=> prdata_q[7:0] == {$past(lock_code), $past(diag_sync)})
        else $error("lock register read data mismatch");

    a_div_assembly: assert property (ce && chan_wr
        |=> {row_ten_q[0], row_eleven_q[7:4]} == $past(lut_div)
        && row_eleven_q[3:1] == $past(lut_band))
        else $error("channel write did not load divider and band");

    a_readback_gate: assert property (ce && setup && !pwrite && hit_lock && !readback_sel
        |=> prdata_q == 32'h0)
        else $error("lock register readable with select low");

    c_lock_read: cover property (setup && hit_lock && readback_sel && lock_code == 2'h1);
    c_chan_apply: cover property (chan_wr ##1 access && hit_view);
    c_fault_irq: cover property ($rose(irq_q) && stat_q[2]);

endmodule : sclr_regs
